// File: core/spi_message_crc_unit.sv
// crc check of commands and crc generation for responses
`timescale 1ns/1ps
`default_nettype none
`include "crc_unit_regs.svh"
module spi_message_crc_unit
  import crc_unit_pkg::*;
#(
  parameter logic [3:0] CRC4_POLY = `CRC4_POLY_DEF,
  parameter logic [3:0] CRC4_SEED = `CRC4_SEED_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        crc4_mode,
  input  wire logic [3:0]  crc_seed_low_nibble,
  input  wire logic        start,
  input  wire logic        op_sel,
  input  wire logic [31:0] msg_in,
  output logic             busy,
  output logic             done_ff,
  output logic             cmd_ok_ff,
  output logic             cmd_err_ff,
  output logic [7:0]       resp_crc_ff,
  output logic [31:0]      resp_msg_ff
);
  // ************************************************************
  // seed and sequencing
  // ************************************************************
  crc_state_t  state_ff;
  crc_op_t     op_ff;
  logic        mode4_ff;
  logic [31:0] msg_ff;
  logic [5:0]  cnt_ff;
  logic [5:0]  total;
  logic [7:0]  seed;
  logic [7:0]  crc_val;
  logic        bit_in;
  logic        load;
  logic        shift;
  logic [31:0] msg_hold_ff;

  always_comb begin
    if (crc4_mode) begin
      seed = {4'h0, CRC4_SEED};
    end else if (crc_seed_low_nibble == 4'h0) begin
      seed = 8'hFF;
    end else begin
      seed = {`CRC8_SEED_HIGH, crc_seed_low_nibble};
    end
  end

  // check feeds 32 bits (message incl. its crc); encode also feeds 32 bits, no extra tail
  always_comb begin
    if (op_ff == op_check) begin
      total = `MSG_BITS;
    end else if (mode4_ff) begin
      total = `MSG_BITS - `CRC4_TAIL + `CRC4_TAIL;
    end else begin
      total = `MSG_BITS - `CRC8_TAIL + `CRC8_TAIL;
    end
  end

  // encode zeroes the crc field of the message so the tail sees zeros
  assign bit_in = (cnt_ff < `MSG_BITS) ? msg_ff[31] : 1'b0;
  assign load   = (state_ff == st_idle) && start;
  assign shift  = (state_ff == st_shift);
  assign busy   = (state_ff != st_idle);

  crc_serial_engine #(
    .POLY4 (CRC4_POLY)
  ) u_engine (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .load    (load),
    .seed    (seed),
    .shift   (shift),
    .bit_in  (bit_in),
    .mode4   (mode4_ff),
    .crc_ff  (crc_val)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= st_idle;
      cnt_ff   <= 6'd0;
    end else begin
      case (state_ff)
        st_idle: begin
          cnt_ff <= 6'd0;
          if (start) begin
            state_ff <= st_shift;
          end
        end
        st_shift: begin
          cnt_ff <= cnt_ff + 6'd1;
          if (cnt_ff == total - 6'd1) begin
            state_ff <= st_done;
          end
        end
        default: begin
          state_ff <= st_idle;
        end
      endcase
    end
  end

  // ************************************************************
  // message capture
  // ************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      msg_ff   <= 32'h0000_0000;
      op_ff    <= op_check;
      mode4_ff <= 1'b0;
    end else if (load) begin
      op_ff    <= crc_op_t'(op_sel);
      mode4_ff <= crc4_mode;
      if (op_sel == op_encode) begin
        msg_ff <= crc4_mode ? {msg_in[31:4], 4'h0}
                            : {msg_in[31:8], 8'h00};
      end else begin
        msg_ff <= msg_in;
      end
    end else if (shift) begin
      msg_ff <= {msg_ff[30:0], 1'b0};
    end
  end

  // ************************************************************
  // results
  // ************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      done_ff     <= 1'b0;
      cmd_ok_ff   <= 1'b0;
      cmd_err_ff  <= 1'b0;
      resp_crc_ff <= 8'h00;
      resp_msg_ff <= 32'h0000_0000;
    end else begin
      done_ff <= (state_ff == st_done);
      if (load) begin
        cmd_ok_ff  <= 1'b0;
        cmd_err_ff <= 1'b0;
      end else if (state_ff == st_done) begin
        if (op_ff == op_check) begin
          cmd_ok_ff  <= (crc_val == 8'h00);
          cmd_err_ff <= (crc_val != 8'h00);
        end else if (mode4_ff) begin
          resp_crc_ff <= {4'h0, crc_val[3:0]};
          resp_msg_ff <= {resp_msg_hi(), crc_val[3:0]};
        end else begin
          resp_crc_ff <= crc_val;
          resp_msg_ff <= {msg_hold_ff[31:8], crc_val};
        end
      end
    end
  end

  // original message kept for building the framed response
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      msg_hold_ff <= 32'h0000_0000;
    end else if (load) begin
      msg_hold_ff <= msg_in;
    end
  end

  function automatic logic [27:0] resp_msg_hi();
    return msg_hold_ff[31:4];
  endfunction : resp_msg_hi
endmodule : spi_message_crc_unit
`default_nettype wire

// File: inc/crc_unit_regs.svh
// constants for the serial message crc unit
`ifndef CRC_UNIT_REGS_SVH
`define CRC_UNIT_REGS_SVH
`define CRC8_POLY        8'h2F
`define CRC8_SEED_HIGH   4'hF
`define CRC4_POLY_DEF    4'h3
`define CRC4_SEED_DEF    4'hF
`define MSG_BITS         6'd32
`define CRC8_TAIL        6'd8
`define CRC4_TAIL        6'd4
`endif

// File: inc/crc_unit_pkg.sv
// types for the serial message crc unit
package crc_unit_pkg;
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_shift = 2'b01,
    st_done  = 2'b10
  } crc_state_t;
  typedef enum logic {
    op_check  = 1'b0,
    op_encode = 1'b1
  } crc_op_t;
endpackage : crc_unit_pkg

// File: core/crc_serial_engine.sv
// serial crc shift register, 8 or 4 bits wide
`timescale 1ns/1ps
`default_nettype none
`include "crc_unit_regs.svh"
module crc_serial_engine #(
  parameter logic [3:0] POLY4 = `CRC4_POLY_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [7:0] seed,
  input  wire logic       shift,
  input  wire logic       bit_in,
  input  wire logic       mode4,
  output logic      [7:0] crc_ff
);
  logic [7:0] nxt_crc;
  logic       fb;
  always_comb begin
    nxt_crc = crc_ff;
    fb      = 1'b0;
    // bits rotate into the lsb; the msb falling out decides the xor
    if (mode4) begin
      fb = crc_ff[3];
      nxt_crc = {4'h0, crc_ff[2:0], bit_in} ^ (fb ? {4'h0, POLY4} : 8'h00);
    end else begin
      fb = crc_ff[7];
      nxt_crc = {crc_ff[6:0], bit_in} ^ (fb ? `CRC8_POLY : 8'h00);
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      crc_ff <= 8'h00;
    end else if (load) begin
      crc_ff <= seed;
    end else if (shift) begin
      crc_ff <= nxt_crc;
    end
  end
endmodule : crc_serial_engine
`default_nettype wire

// File: dv/crc_unit_sva.sv
// crc unit port assertions
`timescale 1ns/1ps
`default_nettype none
module crc_unit_sva (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        start,
  input wire logic        op_sel,
  input wire logic        busy,
  input wire logic        done_ff,
  input wire logic        cmd_ok_ff,
  input wire logic        cmd_err_ff,
  input wire logic [7:0]  resp_crc_ff,
  input wire logic [31:0] resp_msg_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_take; start && !busy; endsequence
  a_done_latency: assert property (s_take |-> ##34 done_ff)
    else $error("late");
  a_busy_hold: assert property (s_take |=> busy [*8])
    else $error("busy");
  a_done_pulse: assert property (done_ff |=> !done_ff)
    else $error("pulse");
  a_flag_excl: assert property (!(cmd_ok_ff && cmd_err_ff))
    else $error("both");
  a_flag_clear: assert property (s_take |=> !cmd_ok_ff && !cmd_err_ff)
    else $error("kept");
  // op_sel is only sampled at start, so look back to that cycle
  a_check_verdict: assert property (
    done_ff && !$past(op_sel, 34) |-> cmd_ok_ff ^ cmd_err_ff)
    else $error("verdict");
  a_crc_stable: assert property (!done_ff |-> $stable(resp_crc_ff))
    else $error("moved");
  a_crc_insert: assert property (resp_msg_ff[3:0] == resp_crc_ff[3:0])
    else $error("insert");
endmodule : crc_unit_sva
bind spi_message_crc_unit crc_unit_sva u_sva (.*);
`default_nettype wire

// File: dv/crc_host_model.sv
// host side crc model
`timescale 1ns/1ps
`default_nettype none
module crc_host_model #(
  parameter logic [3:0] POLY4 = 4'h3,
  parameter logic [3:0] SEED4 = 4'hf
);
  // crc field fed as zeros, so one routine serves build and check
  function automatic logic [7:0] crc_of(logic [31:0] m, logic m4,
    logic [3:0] s);
    logic [7:0] r;
    r = m4 ? {4'h0, SEED4} : {4'hf, (s == 4'h0) ? 4'hf : s};
    for (int i = 31; i >= 0; i--) begin
      if (m4) r = {4'h0, r[2:0], i > 3 && m[i]} ^ (r[3] ? POLY4 : 4'h0);
      else r = {r[6:0], i > 7 && m[i]} ^ (r[7] ? 8'h2f : 8'h00);
    end
    return r;
  endfunction : crc_of
endmodule : crc_host_model
`default_nettype wire

// File: dv/tb_spi_message_crc_unit.sv
// self-checking bench for the crc unit
`timescale 1ns/1ps
`default_nettype none
module tb_spi_message_crc_unit
  import crc_unit_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        crc4_mode = 1'b0;
  logic [3:0]  crc_seed_low_nibble = 4'h0;
  logic        start = 1'b0;
  logic        op_sel = 1'b0;
  logic [31:0] msg_in = 32'h0000_0000;
  logic        busy, done_ff, cmd_ok_ff, cmd_err_ff;
  logic [7:0]  resp_crc_ff;
  logic [31:0] resp_msg_ff;
  logic [31:0] tbl [7] = '{32'h8022_c1bd, 32'h401f_c157, 32'hc022_0066,
    32'h601f_c1b8, 32'h40ff_5ae5, 32'hc03e_0013, 32'h60ff_5a0a};
  int          err_total = 0;
  int          comparisons = 0;
  always #12.5 ref_clk = ~ref_clk;
  spi_message_crc_unit dut (
    .ref_clk             (ref_clk),
    .nrst                (nrst),
    .crc4_mode           (crc4_mode),
    .crc_seed_low_nibble (crc_seed_low_nibble),
    .start               (start),
    .op_sel              (op_sel),
    .msg_in              (msg_in),
    .busy                (busy),
    .done_ff             (done_ff),
    .cmd_ok_ff           (cmd_ok_ff),
    .cmd_err_ff          (cmd_err_ff),
    .resp_crc_ff         (resp_crc_ff),
    .resp_msg_ff         (resp_msg_ff)
  );
  crc_host_model host ();
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic run(logic op, logic m4, logic [3:0] s, logic [31:0] m);
    int n;
    @(posedge ref_clk);
    start <= 1'b1;
    op_sel <= op;
    crc4_mode <= m4;
    crc_seed_low_nibble <= s;
    msg_in <= m;
    @(posedge ref_clk);
    start <= 1'b0;
    for (n = 0; n < 60 && done_ff !== 1'b1; n++) @(negedge ref_clk);
    check("cycles", n, 34);
  endtask : run
  task automatic t_table;
    for (int i = 0; i < 7; i++) begin
      run(op_encode, 1'b0, 4'h0, {tbl[i][31:8], 8'h00});
      check("crc8", resp_msg_ff, tbl[i]);
      run(op_check, 1'b0, 4'h0, tbl[i]);
      check("ok8", cmd_ok_ff, 1'b1);
      run(op_check, 1'b0, 4'h0, tbl[i] ^ (32'h1 << (i * 4)));
      check("err8", {cmd_err_ff, cmd_ok_ff}, 2'b10);
    end
  endtask : t_table
  task automatic t_seed;
    logic [7:0] c;
    for (int n = 1; n < 16; n++) begin
      c = host.crc_of(tbl[1], 1'b0, 4'(n));
      run(op_encode, 1'b0, 4'(n), tbl[1]);
      check("crcs", resp_crc_ff, c);
      run(op_check, 1'b0, 4'(n), {tbl[1][31:8], c});
      check("oks", cmd_ok_ff, 1'b1);
    end
  endtask : t_seed
  task automatic t_mode4;
    logic [31:0] m;
    logic [7:0]  c;
    for (int i = 0; i < 2; i++) begin
      m = i ? 32'h5000_0000 : 32'h8022_c100;
      c = host.crc_of(m, 1'b1, 4'h0);
      run(op_encode, 1'b1, 4'h5, m);
      check("crc4", resp_crc_ff, {4'h0, c[3:0]});
      run(op_check, 1'b1, 4'h5, {m[31:4], c[3:0]});
      check("ok4", cmd_ok_ff, 1'b1);
      run(op_check, 1'b1, 4'h5, {m[31:4], ~c[3:0]});
      check("err4", cmd_err_ff, 1'b1);
    end
  endtask : t_mode4
  task automatic summarize;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    #125000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_table();
    t_seed();
    t_mode4();
    summarize();
  end
endmodule : tb_spi_message_crc_unit
`default_nettype wire
